// ==== logic/ifa_ctrl.sv ====
// Pin request flags, priority arbitration and request acceptance.
// Assumes an APB master on CLK and a CPU core on CLK that drives its mask
// level and pulses when it starts exception processing.
`default_nettype none
// What this block does
// - Status is 16 bits, upper byte zero
// - Pin 0 flag at bit 7, pin 7 at 0
// - Level mode flag follows low pin level
// - Edge mode flag set on falling edge
// - Edge flag cleared by read-one then write-zero
// - Edge flag cleared on its exception start
// - Reset clears flags; standby keeps them
// - Highest programmed level wins arbitration
// - Losing edge requests stay pending
// - Manual reset also drops pending edge flags
// - Ties broken by fixed source order
// - Accept only level above CPU mask
// - Echo pin low while request accepted
// - Echo pin is the inverse of CPU request line
// - Level request releases after mask update
// - Edge request releases at exception start
// - Higher pending request keeps echo low
// - Priority fields four bits, 0 to 15
// - Sense bit: 0 level, 1 falling edge
module ifa_ctrl
  import ifa_pkg::*;
#(
  parameter int unsigned NUM_PER = IFA_NUM_PER  // On-chip peripheral sources
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MANUAL_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [IFA_NUM_PINS-1:0] EXT_REQUEST_PINS_N,
  input wire logic [NUM_PER-1:0] PER_REQ,
  input wire logic [IFA_PRIO_W-1:0] CPU_MASK_LEVEL,
  input wire logic CPU_EXC_START,
  output logic CPU_IRQ_REQ,
  output logic [IFA_PRIO_W-1:0] CPU_IRQ_LEVEL,
  output logic [IFA_SRC_W-1:0] CPU_IRQ_SOURCE,
  output logic REQUEST_ECHO_PIN_N
);
  localparam int unsigned NSRC = IFA_NUM_PINS + NUM_PER;  // All sources

  // ***************************************************************
  // Elaboration check
  // ***************************************************************
  generate
    if (NUM_PER < 1 || NUM_PER > 4) begin : g_bad_per
      $error("ifa_ctrl: NUM_PER must be 1 to 4, one priority register");
    end
  endgenerate

  // ***************************************************************
  // State
  // ***************************************************************
  logic [IFA_NUM_PINS-1:0] flag_r;  // Edge-latched requests, pin index order
  logic [IFA_NUM_PINS-1:0] armed_r;  // Flag was read as one, may be cleared
  logic [IFA_NUM_PINS-1:0] sense_r;  // One selects falling-edge sensing
  logic [15:0] prio_a_r;  // Pins 0..3, pin 0 in the top nibble
  logic [15:0] prio_b_r;  // Pins 4..7
  logic [15:0] prio_c_r;  // Peripherals, source 0 in the top nibble
  ifa_bus_t bus_r;  // APB access tracking
  logic [31:0] prdata_r;  // Read data held for the access phase
  logic pslverr_r;  // Unmapped address seen
  logic req_r;  // Request line to the CPU
  logic [IFA_PRIO_W-1:0] lvl_r;  // Level presented with the request
  logic [IFA_SRC_W-1:0] src_r;  // Source presented with the request
  logic pready_r;  // Answer flag, high in the last access cycle
  logic echo_n_r;  // Echo pin copy of the request line, active low

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [IFA_NUM_PINS-1:0] low_lvl;  // Pin held low, synchronised
  logic [IFA_NUM_PINS-1:0] fall;  // One-cycle falling-edge pulse

  ifa_pin_sync #(
    .WIDTH(IFA_NUM_PINS)
  ) u_sync (
    .CLK(CLK),
    .RESET(RESET),
    .pin_n(EXT_REQUEST_PINS_N),
    .low_lvl(low_lvl),
    .fall(fall)
  );

  // ***************************************************************
  // Decoding helpers
  // ***************************************************************
  // Status bit position of a pin: pin 0 sits at bit 7
  function automatic logic [7:0] pin_to_status(input logic [IFA_NUM_PINS-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < IFA_NUM_PINS; i++) begin
      r[7 - i] = v[i];
    end
    return r;
  endfunction : pin_to_status

  // Priority nibble of a source; nibble 0 of each register is the top one
  function automatic logic [IFA_PRIO_W-1:0] prio_of(input int unsigned s,
      input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    logic [15:0] w;
    int unsigned k;
    w = (s < 4) ? a : (s < 8) ? b : c;
    k = 3 - (s % 4);
    return w[k*4 +: 4];
  endfunction : prio_of

  // ***************************************************************
  // APB access decode
  // ***************************************************************
  logic acc_done;  // Access phase edge where PREADY is sampled high
  logic wr_done;  // Write takes effect on this edge
  logic rd_done;  // Read data is taken on this edge
  logic hit_status;  // Address selects the status register
  logic mapped;  // Address selects any register

  assign acc_done = PSEL & PENABLE & (bus_r == IFA_BUS_DONE);
  assign wr_done = acc_done & PWRITE;
  assign rd_done = acc_done & ~PWRITE;
  assign hit_status = (PADDR == IFA_OFS_STATUS);
  assign mapped = hit_status | (PADDR == IFA_OFS_SENSE) | (PADDR == IFA_OFS_PRIO_A)
                | (PADDR == IFA_OFS_PRIO_B) | (PADDR == IFA_OFS_PRIO_C)
                | (PADDR == IFA_OFS_ACCEPT);

  // Bus phase: two wait states so every APB output comes from a flop
  always_ff @(posedge CLK) begin
    if (RESET) begin
      bus_r <= IFA_BUS_IDLE;
      pready_r <= 1'b0;
    end else begin
      // Rises as the phase enters DONE, so the port needs no decode
      pready_r <= (bus_r == IFA_BUS_WAIT);
      case (bus_r)
        IFA_BUS_IDLE: begin
          // Access phase seen: answer two edges later
          if (PSEL && PENABLE) begin
            bus_r <= IFA_BUS_WAIT;
          end
        end
        IFA_BUS_WAIT: begin
          bus_r <= IFA_BUS_DONE;
        end
        IFA_BUS_DONE: begin
          bus_r <= IFA_BUS_IDLE;
        end
        default: begin
          bus_r <= IFA_BUS_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Status view and read data
  // ***************************************************************
  logic [IFA_NUM_PINS-1:0] pin_view;  // What each pin flag reads as

  // Level-sensed pins show the pin itself, edge-sensed pins the latch
  assign pin_view = (sense_r & flag_r) | (~sense_r & low_lvl);

  // Read data is captured on the same edge where PREADY rises and then held
  always_ff @(posedge CLK) begin
    if (RESET) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (bus_r == IFA_BUS_WAIT) begin
      pslverr_r <= ~mapped;
      prdata_r <= 32'h0000_0000;
      case (PADDR)
        // Upper byte of the 16-bit status stays zero
        IFA_OFS_STATUS: prdata_r[7:0] <= pin_to_status(pin_view);
        IFA_OFS_SENSE: prdata_r[7:0] <= pin_to_status(sense_r);
        IFA_OFS_PRIO_A: prdata_r[15:0] <= prio_a_r;
        IFA_OFS_PRIO_B: prdata_r[15:0] <= prio_b_r;
        IFA_OFS_PRIO_C: prdata_r[15:0] <= prio_c_r;
        IFA_OFS_ACCEPT: begin
          prdata_r[IFA_ACC_REQ_BIT] <= req_r;
          prdata_r[IFA_ACC_LVL_LSB +: IFA_PRIO_W] <= lvl_r;
          prdata_r[IFA_ACC_SRC_LSB +: IFA_SRC_W] <= src_r;
        end
        default: prdata_r <= 32'h0000_0000;  // Unmapped reads as zero
      endcase
    end else begin
      pslverr_r <= 1'b0;  // Error stands for the answer cycle only
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  // Sense select and priorities; writes to unmapped space are dropped
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sense_r <= IFA_RST_SENSE;
      prio_a_r <= IFA_RST_PRIO;
      prio_b_r <= IFA_RST_PRIO;
      prio_c_r <= IFA_RST_PRIO;
    end else if (wr_done) begin
      case (PADDR)
        IFA_OFS_SENSE: begin
          for (int i = 0; i < IFA_NUM_PINS; i++) begin
            sense_r[i] <= PWDATA[7 - i];
          end
        end
        IFA_OFS_PRIO_A: prio_a_r <= PWDATA[15:0];
        IFA_OFS_PRIO_B: prio_b_r <= PWDATA[15:0];
        IFA_OFS_PRIO_C: prio_c_r <= PWDATA[15:0];
        default: begin
        end
      endcase
    end
  end

  // ***************************************************************
  // Edge flags
  // ***************************************************************
  logic [IFA_NUM_PINS-1:0] ack_clr;  // Edge flag served by the CPU now
  logic [IFA_NUM_PINS-1:0] sw_clr;  // Software withdraws a read-one flag
  logic [7:0] wr_stat;  // Written status byte in pin index order

  always_comb begin
    ack_clr = '0;
    wr_stat = 8'h00;
    for (int i = 0; i < IFA_NUM_PINS; i++) begin
      wr_stat[i] = PWDATA[7 - i];
    end
    // The source on the request line is the one being served
    if (CPU_EXC_START && req_r && (src_r < IFA_SRC_W'(IFA_NUM_PINS))) begin
      ack_clr[src_r[2:0]] = sense_r[src_r[2:0]];
    end
  end

  // Only a zero written to a flag read as one clears it; ones and the
  // reserved byte do nothing
  assign sw_clr = (wr_done && hit_status) ? (armed_r & ~wr_stat) : '0;

  // A new falling edge wins over a software or exception clear in the same cycle, but a manual reset drops it. Standby has
  // no input here, so it cannot disturb the flags.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      flag_r <= IFA_RST_FLAGS;
    end else if (MANUAL_RESET) begin
      flag_r <= IFA_RST_FLAGS & fall & sense_r;
    end else begin
      // Pending flags stay until served or withdrawn
      flag_r <= (flag_r & ~sw_clr & ~ack_clr) | (fall & sense_r);
    end
  end

  // Arming: a status read that returned one for an edge flag
  always_ff @(posedge CLK) begin
    if (RESET || MANUAL_RESET) begin
      armed_r <= '0;
    end else if (rd_done && hit_status) begin
      for (int i = 0; i < IFA_NUM_PINS; i++) begin
        armed_r[i] <= prdata_r[7 - i] & sense_r[i] & flag_r[i];
      end
    end else begin
      armed_r <= armed_r & flag_r & ~sw_clr & ~ack_clr;
    end
  end

  // ***************************************************************
  // Arbitration and acceptance
  // ***************************************************************
  logic [NSRC-1:0] pend;  // Requests taking part, served flag removed
  logic found;  // Some request is present
  logic [IFA_PRIO_W-1:0] best_lvl;  // Highest level present
  logic [IFA_SRC_W-1:0] best_src;  // Its source number
  logic accept;  // Best level beats the CPU mask

  // Scan from the last source down with >= so the lowest source number
  // wins a tie; pins come before peripherals in the fixed order
  always_comb begin
    pend = {PER_REQ, ((sense_r & flag_r & ~ack_clr) | (~sense_r & low_lvl))};
    found = 1'b0;
    best_lvl = '0;
    best_src = '0;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (pend[s] && (!found || prio_of(s, prio_a_r, prio_b_r, prio_c_r) >= best_lvl)) begin
        found = 1'b1;
        best_lvl = prio_of(s, prio_a_r, prio_b_r, prio_c_r);
        best_src = IFA_SRC_W'(s);
      end
    end
    accept = found && (best_lvl > CPU_MASK_LEVEL);
  end

  // Request line, level and source to the CPU. A level request drops once
  // the mask catches up; a served edge flag drops at exception start
  // unless another request still beats the mask, which keeps it low.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_r <= 1'b0;
      echo_n_r <= 1'b1;
      lvl_r <= '0;
      src_r <= '0;
    end else begin
      req_r <= accept;
      echo_n_r <= ~accept;
      lvl_r <= accept ? best_lvl : '0;
      src_r <= accept ? best_src : '0;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign CPU_IRQ_REQ = req_r;
  assign CPU_IRQ_LEVEL = lvl_r;
  assign CPU_IRQ_SOURCE = src_r;
  assign REQUEST_ECHO_PIN_N = echo_n_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  chk_upper_zero: assert property (
    (rd_done && hit_status) |-> (PRDATA[31:8] == 24'h000000))
    else $error("status upper bits not zero");
  chk_level_follow: assert property (
    (!sense_r[0] && !$changed(low_lvl[0]) && rd_done && hit_status)
      |-> (PRDATA[7] == low_lvl[0]))
    else $error("level flag does not follow pin");
  chk_edge_set: assert property (
    (fall[3] && sense_r[3] && !MANUAL_RESET) |=> flag_r[3])
    else $error("edge flag not set after falling edge");
  chk_unarmed_hold: assert property (
    (wr_done && hit_status && flag_r[2] && !armed_r[2] && !ack_clr[2]) |=> flag_r[2])
    else $error("flag cleared without prior read of one");
  chk_ack_clear: assert property (
    (ack_clr[0] && !fall[0] && !MANUAL_RESET) |=> !flag_r[0])
    else $error("served edge flag not cleared");
  chk_manual_drop: assert property (
    (MANUAL_RESET && (fall == '0)) |=> (flag_r == '0))
    else $error("manual reset left pending flags");
  chk_above_mask: assert property (
    CPU_IRQ_REQ |-> (CPU_IRQ_LEVEL > $past(CPU_MASK_LEVEL)))
    else $error("request at or below mask level");
  chk_echo_match: assert property (
    REQUEST_ECHO_PIN_N == !CPU_IRQ_REQ)
    else $error("echo pin differs from request line");
  chk_bus_answer: assert property (
    (PSEL && PENABLE && bus_r == IFA_BUS_IDLE) |-> ##2 PREADY)
    else $error("bus answer not two cycles after access");
  cov_edge_accept: cover property (fall[0] && sense_r[0] ##[1:4] CPU_IRQ_REQ);
  cov_sw_withdraw: cover property (sw_clr != '0);
  cov_stay_low: cover property (CPU_EXC_START && CPU_IRQ_REQ ##1 CPU_IRQ_REQ);
endmodule : ifa_ctrl
`default_nettype wire

// ==== logic/ifa_pin_sync.sv ====
// Two-stage synchroniser and falling-edge detector for the request pins.
// Assumes pins are asynchronous to CLK and idle high.
`default_nettype none
module ifa_pin_sync
  import ifa_pkg::*;
#(
  parameter int unsigned WIDTH = IFA_NUM_PINS
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] pin_n,
  output logic [WIDTH-1:0] low_lvl,
  output logic [WIDTH-1:0] fall
);
  // ***************************************************************
  // Per-pin stages
  // ***************************************************************
  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second
  logic [WIDTH-1:0] sync_r;  // Second stage, safe to use
  logic [WIDTH-1:0] prev_r;  // Previous safe level for edge detect

  generate
    if (WIDTH < 1 || WIDTH > IFA_NUM_PINS) begin : g_bad
      $error("ifa_pin_sync: WIDTH out of range");
    end
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      // Synchroniser chain; reset to the idle-high level
      always_ff @(posedge CLK) begin
        if (RESET) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
          prev_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pin_n[i];
          sync_r[i] <= meta_r[i];
          prev_r[i] <= sync_r[i];
        end
      end
      // Active-high view of a low pin, and a one-cycle falling pulse
      assign low_lvl[i] = ~sync_r[i];
      assign fall[i] = prev_r[i] & ~sync_r[i];
    end
  endgenerate
endmodule : ifa_pin_sync
`default_nettype wire

// ==== logic/ifa_pkg.sv ====
// Constants shared by the request flag and acceptance controller.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`default_nettype none
package ifa_pkg;
  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int unsigned IFA_NUM_PINS = 8;  // External request pins
  localparam int unsigned IFA_NUM_PER = 4;  // Default on-chip peripheral sources
  localparam int unsigned IFA_PRIO_W = 4;  // Width of one priority field
  localparam int unsigned IFA_SRC_W = 4;  // Width of a source number
  localparam int unsigned IFA_STAT_W = 16;  // Width of the status register
  // ***************************************************************
  // Register byte offsets
  // ***************************************************************
  localparam logic [11:0] IFA_OFS_STATUS = 12'h000;  // pin_request_status
  localparam logic [11:0] IFA_OFS_SENSE = 12'h004;  // pin_sense_select
  localparam logic [11:0] IFA_OFS_PRIO_A = 12'h008;  // Priorities of pins 0..3
  localparam logic [11:0] IFA_OFS_PRIO_B = 12'h00c;  // Priorities of pins 4..7
  localparam logic [11:0] IFA_OFS_PRIO_C = 12'h010;  // Priorities of peripherals
  localparam logic [11:0] IFA_OFS_ACCEPT = 12'h014;  // Current request view
  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned IFA_ACC_REQ_BIT = 8;  // Request line in accept view
  localparam int unsigned IFA_ACC_LVL_LSB = 4;  // Level field in accept view
  localparam int unsigned IFA_ACC_SRC_LSB = 0;  // Source field in accept view
  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] IFA_RST_FLAGS = 8'h00;  // No request latched
  localparam logic [7:0] IFA_RST_SENSE = 8'h00;  // All pins low-level sensed
  localparam logic [15:0] IFA_RST_PRIO = 16'h0000;  // All levels lowest
  localparam logic [7:0] IFA_RST_PIN_SYNC = 8'hff;  // Idle pins sit high
  // ***************************************************************
  // APB access phases
  // ***************************************************************
  typedef enum logic [1:0] {
    IFA_BUS_IDLE,
    IFA_BUS_WAIT,
    IFA_BUS_DONE
  } ifa_bus_t;
endpackage : ifa_pkg
`default_nettype wire

// ==== test/ifa_cpu_model.sv ====
// CPU core stand-in for the request link: takes requests, starts exceptions.
// Assumes the controller on the same clock; the bench sets mask and delay.
`default_nettype none
module ifa_cpu_model
  import ifa_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic take_en,
  input wire logic [3:0] wait_cyc,
  input wire logic [3:0] mask_set,
  input wire logic mask_wr,
  input wire logic irq_req,
  input wire logic [IFA_PRIO_W-1:0] irq_level,
  input wire logic [IFA_SRC_W-1:0] irq_source,
  output logic exc_start,
  output logic [IFA_PRIO_W-1:0] mask_level,
  output logic [IFA_SRC_W-1:0] vec_src,
  output int n_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;  // Decode delay, the instruction still in flight
  int busy;  // Context push in progress, request not sampled
  int n_push;  // Words pushed to the stack
  logic [3:0] lvl_q;  // Level of the request being taken
  logic [3:0] src_q;  // Source of the request being taken
  // Exception entry; the pulse comes only while the request stands, and a
  // busy spell after it keeps a stale request from being taken twice
  always @(posedge clk) begin
    if (rst) begin
      exc_start <= 1'b0;
      mask_level <= 4'h0;
      vec_src <= 4'h0;
      n_taken <= 0;
      n_push = 0;
      cnt = 0;
      busy = 0;
    end else if (exc_start) begin
      exc_start <= 1'b0;
      mask_level <= lvl_q;
      vec_src <= src_q;  // Straight to the source's routine
      n_push = n_push + 2;
      busy = 4;
    end else if (mask_wr) begin
      mask_level <= mask_set;
    end else if (busy > 0) begin
      busy = busy - 1;
    end else if (take_en && irq_req === 1'b1) begin
      if (cnt >= int'(wait_cyc)) begin
        exc_start <= 1'b1;
        lvl_q <= irq_level;
        src_q <= irq_source;
        n_taken <= n_taken + 1;
        cnt = 0;
      end else begin
        cnt = cnt + 1;
      end
    end
  end
endmodule : ifa_cpu_model
`default_nettype wire

// ==== test/irq_flags_and_acceptance_test.sv ====
// Self-checking bench for the request flags and acceptance controller.
// Assumes ifa_ctrl, ifa_pkg and the CPU model are compiled before it.
`default_nettype none
module irq_flags_and_acceptance_test;
  import ifa_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic [7:0] pins_n = 8'hff;  // Idle high
  logic [3:0] per = 4'h0;
  logic [3:0] mask;
  logic exc;
  logic irq;
  logic [3:0] lvl;
  logic [3:0] src;
  logic echo_n;
  logic take_en = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic [3:0] mask_set = 4'h0;
  logic mask_wr = 1'b0;
  int n_taken;
  logic [3:0] vec;  // Source whose routine the CPU model entered
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'h07994c1e;
  logic [7:0] sense_m = 8'h00;  // Model: bit n is pin n
  logic [7:0] edge_m = 8'h00;  // Model: latched edge requests
  int prio_m[12];  // Model: level of each source
  logic [31:0] q;
  logic [15:0] v;
  logic [7:0] r;
  always #50 clk = ~clk;
  ifa_ctrl #(.NUM_PER(4)) u_ifa_ctrl (.CLK(clk), .RESET(rst), .MANUAL_RESET(mrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_REQUEST_PINS_N(pins_n),
    .PER_REQ(per), .CPU_MASK_LEVEL(mask), .CPU_EXC_START(exc), .CPU_IRQ_REQ(irq),
    .CPU_IRQ_LEVEL(lvl), .CPU_IRQ_SOURCE(src), .REQUEST_ECHO_PIN_N(echo_n));
  ifa_cpu_model u_ifa_cpu_model (.clk(clk), .rst(rst), .take_en(take_en),
    .wait_cyc(wait_cyc), .mask_set(mask_set), .mask_wr(mask_wr), .irq_req(irq),
    .irq_level(lvl), .irq_source(src), .exc_start(exc), .mask_level(mask),
    .vec_src(vec), .n_taken(n_taken));
  // Expected status byte: pin 0 lands in bit 7
  function automatic logic [7:0] flags_m();
    logic [7:0] f;
    for (int n = 0; n < 8; n++) f[7-n] = sense_m[n] ? edge_m[n] : !pins_n[n];
    return f;
  endfunction : flags_m
  // Expected accept view; strict greater keeps the lowest source on a tie
  function automatic logic [31:0] acc_m();
    int best;
    int bl;
    logic [7:0] f;
    best = -1;
    bl = 0;
    f = flags_m();
    for (int s = 0; s < 12; s++) begin
      if ((s < 8 ? f[7-s] : per[s-8]) && (best < 0 || prio_m[s] > bl)) begin
        best = s;
        bl = prio_m[s];
      end
    end
    if (best < 0 || bl <= int'(mask)) return 32'h0;
    return {23'h0, 1'b1, 4'(bl), 4'(best)};
  endfunction : acc_m
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd_chk
  task automatic chk_cpu();
    logic [31:0] e;
    e = acc_m();
    chk({23'h0, irq, lvl, src}, e);
    chk({31'h0, echo_n}, {31'h0, ~e[8]});
  endtask : chk_cpu
  task automatic set_mask(input logic [3:0] m);
    mask_set <= m;
    mask_wr <= 1'b1;
    @(posedge clk);
    mask_wr <= 1'b0;
  endtask : set_mask
  // Falling edges on the pins set in p, with sync time on both sides
  task automatic pulse(input logic [7:0] p);
    pins_n <= ~p;
    repeat (4) @(posedge clk);
    pins_n <= 8'hff;
    repeat (4) @(posedge clk);
    edge_m = edge_m | p;
  endtask : pulse
  task automatic end_of_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // Watchdog: whole run needs well under 3000 cycles
  initial begin
    #(100 * 20000);
    n_fail++;
    end_of_test();
  end
  initial begin
    for (int s = 0; s < 12; s++) prio_m[s] = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(IFA_OFS_STATUS, 32'h0);
    rd_chk(IFA_OFS_ACCEPT, 32'h0);
    chk({31'h0, err}, 32'h0);
    rd_chk(12'h0f0, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test done");
    repeat (8) begin
      pins_n <= 8'($random(seed));
      repeat (4) @(posedge clk);
      rd_chk(IFA_OFS_STATUS, {24'h0, flags_m()});
    end
    pins_n <= 8'hff;
    apb(1'b1, IFA_OFS_SENSE, 32'hff);
    sense_m = 8'hff;
    rd_chk(IFA_OFS_SENSE, 32'hff);
    rd_chk(IFA_OFS_STATUS, 32'h0);
    pulse(8'($random(seed)) | 8'h01);
    apb(1'b1, IFA_OFS_STATUS, 32'h0);
    rd_chk(IFA_OFS_STATUS, {24'h0, flags_m()});
    apb(1'b1, IFA_OFS_STATUS, 32'hffff);
    rd_chk(IFA_OFS_STATUS, {24'h0, flags_m()});
    apb(1'b1, IFA_OFS_STATUS, 32'h0);
    edge_m = 8'h00;
    rd_chk(IFA_OFS_STATUS, 32'h0);
    $display("edge flag test done");
    for (int it = 0; it < 8; it++) begin
      r = 8'($random(seed));
      v = it[0] ? 16'($random(seed)) : {4{r[3:0]}};  // Even passes give ties
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, IFA_OFS_PRIO_A + 12'(4 * k), {16'h0, v});
        for (int j = 0; j < 4; j++) prio_m[4*k+j] = int'(v[15-4*j -: 4]);
      end
      rd_chk(IFA_OFS_PRIO_C, {16'h0, v});
      pulse(8'($random(seed)));
      per <= 4'($random(seed));
      set_mask(4'($random(seed)));
      repeat (3) @(posedge clk);
      chk_cpu();
      rd_chk(IFA_OFS_ACCEPT, acc_m());
      rd_chk(IFA_OFS_STATUS, {24'h0, flags_m()});
      apb(1'b1, IFA_OFS_STATUS, 32'h0);
      edge_m = 8'h00;
    end
    $display("arbitration test done");
    per <= 4'h0;
    set_mask(4'h0);
    apb(1'b1, IFA_OFS_PRIO_A, 32'h3700);
    apb(1'b1, IFA_OFS_PRIO_B, 32'h0);
    apb(1'b1, IFA_OFS_PRIO_C, 32'h5000);
    prio_m = '{3, 7, 0, 0, 0, 0, 0, 0, 5, 0, 0, 0};
    wait_cyc <= 4'($random(seed));
    take_en <= 1'b1;
    pulse(8'h03);
    while (n_taken < 1) @(posedge clk);
    repeat (3) @(posedge clk);
    edge_m = 8'h01;
    chk({28'h0, mask}, 32'h7);
    chk({28'h0, vec}, 32'h1);
    rd_chk(IFA_OFS_STATUS, {24'h0, flags_m()});
    chk_cpu();
    per <= 4'h1;
    set_mask(4'h0);
    while (n_taken < 2) @(posedge clk);
    repeat (3) @(posedge clk);
    chk({28'h0, mask}, 32'h5);
    chk({28'h0, vec}, 32'h8);
    chk_cpu();
    take_en <= 1'b0;
    mrst <= 1'b1;
    @(posedge clk);
    mrst <= 1'b0;
    edge_m = 8'h00;
    rd_chk(IFA_OFS_STATUS, 32'h0);
    set_mask(4'h0);
    repeat (3) @(posedge clk);
    chk_cpu();
    $display("acceptance test done");
    end_of_test();
  end
endmodule : irq_flags_and_acceptance_test
`default_nettype wire
